/* src/mfv_regs_map.vh */
// Functional notes
// R1 - Upper frame size register holds bits 10:8 in 2:0, resets 06h, rest reserved.
// R2 - Flow control is enabled only while flow bit 7 is one; resets off.
// R3 - Bit 6 applies back pressure in half duplex; ignored in full duplex.
// R4 - Flow field 5:0 is high-water free-page threshold in 256-byte pages, reset 7.
// R5 - Reading MAC config bit 7 returns the duplex the MAC really runs.
// R6 - Full duplex if written bit or transmit config bit 7; ignored with internal PHY.
// R7 - MAC bit 6 clear lets back pressure leak after jam-limit collisions; set never.
// R8 - MAC bit 5 lets transmit starts be accepted without waiting for completion.
// R9 - MAC bit 4 selects media: zero internal PHY, one external MII PHY.
// R10 - Tag filter accepts tagged frames only; mismatching nonzero VLAN ID is rejected.
// R11 - Test bit 2: back off 2 slots after first collision, 0 after second.
// R12 - Test bit 1 limits each collision back-off to 0 to 3 slots.
// R13 - Test bit 0 forces zero back-off after every collision.
// R14 - Host writes zero to all three back-off test bits in normal use.
// R15 - 12-bit VLAN ID, priority 7:5 and format flag 4 from two write-only registers.
// R16 - Status bit 7 shows transmit command queue full; host checks it first.
// R17 - Field 6:0 takes transmit end page after clean transmit; 00h on reset or stop.
// R18 - Byte order little-endian while register is zero, big-endian if any bit set.
// R19 - Writing one to wake-up register leaves D2; bit clears once awake.
// R20 - Leak collision count comes from 6-bit jam-limit register, reset 19h.
// R21 - Low frame size byte is separate; combined reset value is 1536 bytes.
// R22 - Received frames longer than the programmed maximum are flagged oversize.
`ifndef MFV_REGS_MAP_VH
`define MFV_REGS_MAP_VH

`define MFV_ADDR_W 5
`define MFV_OFF_JAM_LIMIT 5'h17
`define MFV_OFF_LIMIT_LOWER 5'h18
`define MFV_OFF_LIMIT_UPPER 5'h19
`define MFV_OFF_FLOW 5'h1a
`define MFV_OFF_MAC 5'h1b
`define MFV_OFF_VID_LOW 5'h1c
`define MFV_OFF_TX_END_PAGE 5'h1c
`define MFV_OFF_VID_HIGH 5'h1d
`define MFV_OFF_BYTE_ORDER 5'h1e
`define MFV_OFF_WAKE 5'h1f

`define MFV_RST_LIMIT_LOWER 8'h00
`define MFV_RST_LIMIT_UPPER 3'h6
`define MFV_RST_FLOW 8'h07
`define MFV_RST_MAC 8'h00
`define MFV_RST_JAM_LIMIT 6'h19
`define MFV_RST_TX_END_PAGE 7'h00
`define MFV_RST_BYTE_ORDER 8'h00
`define MFV_RST_VID_LOW 8'h00
`define MFV_RST_VID_HIGH 8'h00

`define MFV_FLOW_EN_BIT 7
`define MFV_FLOW_BP_BIT 6
`define MFV_FLOW_HIGH_WATER_PAGE_THRESHOLD_MSB 5
`define MFV_MAC_DUPLEX_BIT 7
`define MFV_MAC_LEAK_BIT 6
`define MFV_MAC_B2B_BIT 5
`define MFV_MAC_MEDIA_BIT 4
`define MFV_MAC_TAG_BIT 3
`define MFV_MAC_FIRST_BIT 2
`define MFV_MAC_SHORT_BIT 1
`define MFV_MAC_ZERO_BIT 0
`define MFV_VID_PRI_MSB 7
`define MFV_VID_PRI_LSB 5
`define MFV_VID_CFI_BIT 4
`define MFV_VID_HI_MSB 3
`define MFV_UPPER_MSB 2
`define MFV_JAM_MSB 5
`define MFV_TEP_FULL_BIT 7
`define MFV_TEP_PAGE_MSB 6
`define MFV_WAKE_BIT 0

`define MFV_TAG_TYPE 16'h8100
`define MFV_VID_NULL 12'h000
`define MFV_COLL_MAX 6'h3f
`define MFV_ATTEMPT_FIRST 4'h1
`define MFV_ATTEMPT_SECOND 4'h2
`define MFV_SLOTS_FIRST 10'h002
`define MFV_SLOTS_SHORT_MASK 10'h003

`endif

/* src/mfv_backoff_ctl.v */
`timescale 1ns/1ps
`include "mfv_regs_map.vh"
module mfv_backoff_ctl #(
	parameter SLOT_W = 10
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Back-off request
	input wire backoff_req,
	input wire [3:0] attempt_num,
	input wire [SLOT_W-1:0] rand_slots,
	// Test modes
	input wire first_collision_backoff_test,
	input wire short_backoff_test,
	input wire no_backoff_test,
	// Result
	output reg [SLOT_W-1:0] backoff_slots,
	output reg backoff_valid
);

	reg [SLOT_W-1:0] slots_nxt;
	reg [SLOT_W-1:0] range_mask;
	integer i;

	// Truncated binary exponential range, capped at SLOT_W bits
	always @* begin
		range_mask = {SLOT_W{1'b0}};
		for (i = 0; i < SLOT_W; i = i + 1) begin
			if (i < attempt_num)
				range_mask[i] = 1'b1;
		end
	end

	// Zero back-off outranks the other test modes
	always @* begin
		slots_nxt = rand_slots & range_mask;
		if (no_backoff_test) begin
			slots_nxt = {SLOT_W{1'b0}}; // R13
		end else if (first_collision_backoff_test &&
			attempt_num == `MFV_ATTEMPT_FIRST) begin
			slots_nxt = `MFV_SLOTS_FIRST; // R11
		end else if (first_collision_backoff_test &&
			attempt_num == `MFV_ATTEMPT_SECOND) begin
			slots_nxt = {SLOT_W{1'b0}}; // R11
		end else if (short_backoff_test) begin
			slots_nxt = rand_slots & `MFV_SLOTS_SHORT_MASK; // R12
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			backoff_slots <= {SLOT_W{1'b0}};
			backoff_valid <= 1'b0;
		end else begin
			backoff_valid <= backoff_req;
			if (backoff_req)
				backoff_slots <= slots_nxt;
		end
	end

endmodule

/* src/mfv_config_regs.v */
`timescale 1ns/1ps
`include "mfv_regs_map.vh"
module mfv_config_regs #(
	parameter SLOT_W = 10
) (
	// Clock and reset
	input wire clock,
	input wire reset_n,
	// Host bus pins
	input wire host_cs_n,
	input wire host_rd_n,
	input wire host_wr_n,
	input wire [4:0] host_addr,
	input wire [7:0] host_data_in,
	output reg [7:0] host_data_out,
	output reg host_data_oe,
	// Transmit side
	input wire tcr_full_duplex,
	input wire transmit_start_cmd,
	input wire tx_busy,
	output reg tx_start_accept,
	input wire tx_done_ok,
	input wire tx_stop,
	input wire [6:0] tx_end_page_in,
	input wire tx_queue_full_flag,
	input wire collision,
	input wire backoff_req,
	input wire [3:0] attempt_num,
	input wire [SLOT_W-1:0] rand_slots,
	output wire [SLOT_W-1:0] backoff_slots,
	output wire backoff_valid,
	// PHY and receive side
	input wire phy_full_duplex,
	input wire rx_frame_end,
	input wire [10:0] rx_frame_len,
	input wire [15:0] rx_tag_type,
	input wire [11:0] rx_vlan_id,
	output reg rx_frame_drop,
	output reg rx_oversize,
	// Power management
	input wire device_awake,
	output reg wake_request,
	// Configuration to MAC
	output reg flow_control_enable,
	output reg back_pressure_active,
	output reg mac_full_duplex,
	output reg media_select,
	output reg back_to_back_tx_enable,
	output reg tag_filter_enable,
	output reg [11:0] vlan_id,
	output reg [2:0] tag_precedence,
	output reg canonical_format_flag,
	output reg [10:0] frame_limit,
	output reg [5:0] high_water_page_threshold,
	output reg big_endian
);

	// Reset release
	reg rst_s1_r;
	reg rst_n_r;

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// Host pins come from the MCU's timing, so two stages each
	reg [2:0] ctl_s1_r;
	reg [2:0] ctl_s2_r;
	reg [4:0] addr_s1_r;
	reg [4:0] addr_s2_r;
	reg [7:0] data_s1_r;
	reg [7:0] data_s2_r;

	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctl_s1_r <= 3'h7;
			ctl_s2_r <= 3'h7;
			addr_s1_r <= 5'h00;
			addr_s2_r <= 5'h00;
			data_s1_r <= 8'h00;
			data_s2_r <= 8'h00;
		end else begin
			ctl_s1_r <= {host_cs_n, host_rd_n, host_wr_n};
			ctl_s2_r <= ctl_s1_r;
			addr_s1_r <= host_addr;
			addr_s2_r <= addr_s1_r;
			data_s1_r <= host_data_in;
			data_s2_r <= data_s1_r;
		end
	end

	wire rd_act = !ctl_s2_r[2] && !ctl_s2_r[1];
	wire wr_act = !ctl_s2_r[2] && !ctl_s2_r[0];

	// Commit on strobe release, using values held while it was active
	reg wr_act_d_r;
	reg [4:0] wr_addr_r;
	reg [7:0] wr_data_r;

	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wr_act_d_r <= 1'b0;
			wr_addr_r <= 5'h00;
			wr_data_r <= 8'h00;
		end else begin
			wr_act_d_r <= wr_act;
			if (wr_act) begin
				wr_addr_r <= addr_s2_r;
				wr_data_r <= data_s2_r;
			end
		end
	end

	wire wr_pulse = wr_act_d_r && !wr_act;

	// Register storage
	reg [7:0] limit_lower_r;
	reg [2:0] limit_upper_r;
	reg [7:0] flow_r;
	reg [7:0] mac_r;
	reg [5:0] jam_limit_r;
	reg [7:0] vid_low_r;
	reg [7:0] vid_high_r;
	reg [7:0] byte_order_r;
	reg [6:0] tx_end_page_r;
	reg tx_full_r;
	reg wake_r;

	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			limit_lower_r <= `MFV_RST_LIMIT_LOWER; // R21
			limit_upper_r <= `MFV_RST_LIMIT_UPPER; // R1
			flow_r <= `MFV_RST_FLOW; // R2 R4
			mac_r <= `MFV_RST_MAC; // R9
			jam_limit_r <= `MFV_RST_JAM_LIMIT; // R20
			vid_low_r <= `MFV_RST_VID_LOW;
			vid_high_r <= `MFV_RST_VID_HIGH;
			byte_order_r <= `MFV_RST_BYTE_ORDER; // R18
		end else if (wr_pulse) begin
			if (wr_addr_r == `MFV_OFF_JAM_LIMIT) begin
				jam_limit_r <= wr_data_r[`MFV_JAM_MSB:0]; // R20
			end else if (wr_addr_r == `MFV_OFF_LIMIT_LOWER) begin
				limit_lower_r <= wr_data_r; // R21
			end else if (wr_addr_r == `MFV_OFF_LIMIT_UPPER) begin
				limit_upper_r <= wr_data_r[`MFV_UPPER_MSB:0]; // R1
			end else if (wr_addr_r == `MFV_OFF_FLOW) begin
				flow_r <= wr_data_r;
			end else if (wr_addr_r == `MFV_OFF_MAC) begin
				mac_r <= wr_data_r;
			end else if (wr_addr_r == `MFV_OFF_VID_LOW) begin
				vid_low_r <= wr_data_r; // R15
			end else if (wr_addr_r == `MFV_OFF_VID_HIGH) begin
				vid_high_r <= wr_data_r; // R15
			end else if (wr_addr_r == `MFV_OFF_BYTE_ORDER) begin
				byte_order_r <= wr_data_r;
			end
		end
	end

	// Wake request: a host set wins over the awake clear
	wire wake_set = wr_pulse && wr_addr_r == `MFV_OFF_WAKE &&
		wr_data_r[`MFV_WAKE_BIT];

	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wake_r <= 1'b0;
		end else if (wake_set) begin
			wake_r <= 1'b1; // R19
		end else if (device_awake) begin
			wake_r <= 1'b0; // R19
		end
	end

	// Queue-full status, one cycle behind the queue itself
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_full_r <= 1'b0;
		end else begin
			tx_full_r <= tx_queue_full_flag; // R16
		end
	end

	// Transmit end page; stop clears even if a completion coincides
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_end_page_r <= `MFV_RST_TX_END_PAGE;
		end else begin
			if (tx_stop)
				tx_end_page_r <= `MFV_RST_TX_END_PAGE; // R17
			else if (tx_done_ok)
				tx_end_page_r <= tx_end_page_in; // R17
		end
	end

	// Duplex actually in force
	wire written_fd = mac_r[`MFV_MAC_DUPLEX_BIT] || tcr_full_duplex;
	wire fd_nxt = mac_r[`MFV_MAC_MEDIA_BIT] ? written_fd :
		phy_full_duplex; // R6 R9

	// Consecutive collisions under back pressure
	reg [5:0] consec_coll_r;

	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			consec_coll_r <= 6'h00;
		end else if (tx_done_ok || tx_stop || rx_frame_end) begin
			consec_coll_r <= 6'h00;
		end else if (collision && consec_coll_r != `MFV_COLL_MAX) begin
			consec_coll_r <= consec_coll_r + 6'h01;
		end
	end

	// Leaking stops hub ports partitioning under endless jams
	wire leak = !mac_r[`MFV_MAC_LEAK_BIT] &&
		consec_coll_r >= jam_limit_r; // R7 R20
	wire bp_nxt = flow_r[`MFV_FLOW_EN_BIT] && flow_r[`MFV_FLOW_BP_BIT] &&
		!fd_nxt && !leak; // R2 R3 R7

	// Receive filtering
	wire [10:0] limit_nxt = {limit_upper_r, limit_lower_r};
	wire [11:0] vid_prog = {vid_high_r[`MFV_VID_HI_MSB:0], vid_low_r};
	wire tag_en = mac_r[`MFV_MAC_TAG_BIT];
	wire is_tagged = rx_tag_type == `MFV_TAG_TYPE;
	wire vid_ok = rx_vlan_id == `MFV_VID_NULL || rx_vlan_id == vid_prog;
	wire tag_reject = tag_en && (!is_tagged || !vid_ok); // R10
	wire too_long = rx_frame_len > limit_nxt; // R22

	// Outputs to the MAC
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			flow_control_enable <= 1'b0;
			back_pressure_active <= 1'b0;
			mac_full_duplex <= 1'b0;
			media_select <= 1'b0;
			back_to_back_tx_enable <= 1'b0;
			tag_filter_enable <= 1'b0;
			vlan_id <= 12'h000;
			tag_precedence <= 3'h0;
			canonical_format_flag <= 1'b0;
			frame_limit <= 11'h000;
			high_water_page_threshold <= 6'h00;
			big_endian <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			flow_control_enable <= flow_r[`MFV_FLOW_EN_BIT]; // R2
			back_pressure_active <= bp_nxt; // R3
			mac_full_duplex <= fd_nxt; // R6
			media_select <= mac_r[`MFV_MAC_MEDIA_BIT]; // R9
			back_to_back_tx_enable <= mac_r[`MFV_MAC_B2B_BIT]; // R8
			tag_filter_enable <= tag_en; // R10
			vlan_id <= vid_prog; // R15
			tag_precedence <=
				vid_high_r[`MFV_VID_PRI_MSB:`MFV_VID_PRI_LSB]; // R15
			canonical_format_flag <= vid_high_r[`MFV_VID_CFI_BIT]; // R15
			frame_limit <= limit_nxt; // R1 R21
			high_water_page_threshold <=
				flow_r[`MFV_FLOW_HIGH_WATER_PAGE_THRESHOLD_MSB:0]; // R4
			big_endian <= |byte_order_r; // R18
			wake_request <= wake_r; // R19
		end
	end

	// Transmit start gate
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_start_accept <= 1'b0;
		end else begin
			// Busy only blocks starts when back-to-back is off
			tx_start_accept <= transmit_start_cmd &&
				(mac_r[`MFV_MAC_B2B_BIT] || !tx_busy); // R8
		end
	end

	// Receive verdicts; an oversize frame is never kept
	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rx_frame_drop <= 1'b0;
			rx_oversize <= 1'b0;
		end else begin
			rx_frame_drop <= rx_frame_end &&
				(tag_reject || too_long); // R10 R22
			rx_oversize <= rx_frame_end && too_long; // R22
		end
	end

	// Read path; write-only offsets and the jam limit give no answer
	reg [7:0] rd_nxt;
	reg rd_hit;

	always @* begin
		rd_nxt = 8'h00;
		rd_hit = 1'b1;
		if (addr_s2_r == `MFV_OFF_LIMIT_LOWER) begin
			rd_nxt = limit_lower_r;
		end else if (addr_s2_r == `MFV_OFF_LIMIT_UPPER) begin
			rd_nxt = {5'h00, limit_upper_r}; // R1
		end else if (addr_s2_r == `MFV_OFF_FLOW) begin
			rd_nxt = flow_r;
		end else if (addr_s2_r == `MFV_OFF_MAC) begin
			rd_nxt = mac_r;
			rd_nxt[`MFV_MAC_DUPLEX_BIT] = mac_full_duplex; // R5
		end else if (addr_s2_r == `MFV_OFF_TX_END_PAGE) begin
			rd_nxt = {tx_full_r, tx_end_page_r}; // R16 R17
		end else if (addr_s2_r == `MFV_OFF_BYTE_ORDER) begin
			rd_nxt = byte_order_r;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			host_data_out <= 8'h00;
			host_data_oe <= 1'b0;
		end else begin
			host_data_out <= rd_nxt;
			host_data_oe <= rd_act && rd_hit;
		end
	end

	// Test bits pass straight through; host keeps them zero normally
	mfv_backoff_ctl #(
		.SLOT_W(SLOT_W)
	) u_backoff (
		.clock(clock),
		.rst_n(rst_n_r),
		.backoff_req(backoff_req),
		.attempt_num(attempt_num),
		.rand_slots(rand_slots),
		.first_collision_backoff_test(mac_r[`MFV_MAC_FIRST_BIT]), // R14
		.short_backoff_test(mac_r[`MFV_MAC_SHORT_BIT]),
		.no_backoff_test(mac_r[`MFV_MAC_ZERO_BIT]),
		.backoff_slots(backoff_slots),
		.backoff_valid(backoff_valid)
	);

endmodule

/* verification/mfv_config_monitor.sv */
`timescale 1ns/1ps
module mfv_config_monitor #(
	parameter SLOT_W = 10
) (
	input wire clock,
	input wire reset_n,
	input wire host_cs_n,
	input wire host_rd_n,
	input wire [4:0] host_addr,
	input wire host_data_oe,
	input wire tx_busy,
	input wire transmit_start_cmd,
	input wire tx_start_accept,
	input wire backoff_req,
	input wire [SLOT_W-1:0] rand_slots,
	input wire [SLOT_W-1:0] backoff_slots,
	input wire backoff_valid,
	input wire phy_full_duplex,
	input wire rx_frame_end,
	input wire [10:0] rx_frame_len,
	input wire [15:0] rx_tag_type,
	input wire [11:0] rx_vlan_id,
	input wire rx_frame_drop,
	input wire rx_oversize,
	input wire device_awake,
	input wire wake_request,
	input wire flow_control_enable,
	input wire back_pressure_active,
	input wire mac_full_duplex,
	input wire media_select,
	input wire back_to_back_tx_enable,
	input wire tag_filter_enable,
	input wire [11:0] vlan_id,
	input wire [10:0] frame_limit
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_start_accept: assert property (tx_start_accept == $past(transmit_start_cmd
		&& (back_to_back_tx_enable || !tx_busy)))
		else $error("start accept wrong");
	a_backoff_range: assert property (backoff_req |=> backoff_valid
		&& (backoff_slots == 10'h002 || !(backoff_slots & ~$past(rand_slots))))
		else $error("backoff slots wrong");
	a_oversize_flag: assert property (rx_frame_end |=> rx_oversize ==
		($past(rx_frame_len) > $past(frame_limit)))
		else $error("oversize flag wrong");
	a_tag_drop: assert property (rx_frame_end |=> rx_frame_drop ==
		($past(tag_filter_enable) && ($past(rx_tag_type) != 16'h8100 ||
		($past(rx_vlan_id) != 12'h000 && $past(rx_vlan_id) != $past(vlan_id)))
		|| $past(rx_frame_len) > $past(frame_limit)))
		else $error("tag filter wrong");
	a_phy_duplex: assert property ((!media_select &&
		$stable(phy_full_duplex))[*3] |-> mac_full_duplex == phy_full_duplex)
		else $error("duplex not from phy");
	a_pressure_gate: assert property (back_pressure_active |->
		(flow_control_enable || $past(flow_control_enable)) &&
		!(mac_full_duplex && $past(mac_full_duplex)))
		else $error("pressure not gated");
	a_wake_hold: assert property (wake_request && !$past(device_awake) |=>
		wake_request) else $error("wake dropped early");
	a_wake_clear: assert property (device_awake[*3] |-> !wake_request)
		else $error("wake not cleared");
	a_wo_silent: assert property ((!host_cs_n && !host_rd_n &&
		host_addr == 5'h1d)[*5] |-> !host_data_oe)
		else $error("write-only read answered");
	c_accept: cover property (tx_start_accept);
	c_drop: cover property (rx_frame_drop);
	c_leak: cover property (back_pressure_active ##1 !back_pressure_active);
endmodule

bind mfv_config_regs mfv_config_monitor #(.SLOT_W(SLOT_W))
	mfv_config_monitor_i (.clock, .reset_n, .host_cs_n, .host_rd_n,
	.host_addr, .host_data_oe, .tx_busy, .transmit_start_cmd,
	.tx_start_accept, .backoff_req, .rand_slots, .backoff_slots,
	.backoff_valid, .phy_full_duplex, .rx_frame_end, .rx_frame_len,
	.rx_tag_type, .rx_vlan_id, .rx_frame_drop, .rx_oversize, .device_awake,
	.wake_request, .flow_control_enable, .back_pressure_active,
	.mac_full_duplex, .media_select, .back_to_back_tx_enable,
	.tag_filter_enable, .vlan_id, .frame_limit);

/* verification/mfv_host_model.sv */
`timescale 1ns/1ps
module mfv_host_model (
	// Clock
	input wire clock,
	// Host bus
	output logic host_cs_n,
	output logic host_rd_n,
	output logic host_wr_n,
	output logic [4:0] host_addr,
	output logic [7:0] host_data_in,
	input wire [7:0] host_data_out,
	input wire host_data_oe
);
	logic test_en = 1'b0;
	initial begin
		{host_cs_n, host_rd_n, host_wr_n} = 3'h7;
		host_addr = 5'h00;
		host_data_in = 8'h00;
	end
	task wr(input [4:0] a, input [7:0] d);
		@(posedge clock);
		host_addr <= a;
		host_data_in <= (a == 5'h1b && !test_en) ? d & 8'hf8 : d;
		host_cs_n <= 1'b0;
		host_wr_n <= 1'b0;
		repeat (4) @(posedge clock);
		host_cs_n <= 1'b1;
		host_wr_n <= 1'b1;
		repeat (3) @(posedge clock);
		// Released bus must not keep showing the old value
		host_addr <= ~a;
		host_data_in <= ~d;
		repeat (2) @(posedge clock);
	endtask
	task rd(input [4:0] a, output [7:0] d, output o);
		@(posedge clock);
		host_addr <= a;
		host_cs_n <= 1'b0;
		host_rd_n <= 1'b0;
		repeat (5) @(posedge clock);
		d = host_data_out;
		o = host_data_oe;
		host_cs_n <= 1'b1;
		host_rd_n <= 1'b1;
		host_addr <= ~a;
		repeat (5) @(posedge clock);
	endtask
endmodule

/* verification/mfv_config_regs_tb_top.sv */
`timescale 1ns/1ps
module mfv_config_regs_tb_top;
	logic clock = 0, reset_n = 0, tcr_full_duplex = 0, transmit_start_cmd = 0;
	logic tx_busy = 0, tx_done_ok = 0, tx_stop = 0, tx_queue_full_flag = 0;
	logic collision = 0, backoff_req = 0, phy_full_duplex = 0;
	logic rx_frame_end = 0, device_awake = 0, o;
	logic [6:0] tx_end_page_in = 7'h00;
	logic [3:0] attempt_num = 4'h0;
	logic [9:0] rand_slots = 10'h000;
	logic [10:0] rx_frame_len = 11'h000;
	logic [15:0] rx_tag_type = 16'h0000;
	logic [11:0] rx_vlan_id = 12'h000;
	logic [7:0] d;
	wire host_cs_n, host_rd_n, host_wr_n, host_data_oe, tx_start_accept;
	wire backoff_valid, rx_frame_drop, rx_oversize, wake_request;
	wire flow_control_enable, back_pressure_active, mac_full_duplex;
	wire media_select, back_to_back_tx_enable, tag_filter_enable;
	wire canonical_format_flag, big_endian;
	wire [4:0] host_addr;
	wire [7:0] host_data_in, host_data_out;
	wire [9:0] backoff_slots;
	wire [11:0] vlan_id;
	wire [2:0] tag_precedence;
	wire [10:0] frame_limit;
	wire [5:0] high_water_page_threshold;
	int err_count = 0, comparisons = 0;

	mfv_config_regs #(.SLOT_W(10)) mfv_config_regs_i (.clock, .reset_n,
		.host_cs_n, .host_rd_n, .host_wr_n, .host_addr, .host_data_in,
		.host_data_out, .host_data_oe, .tcr_full_duplex, .transmit_start_cmd,
		.tx_busy, .tx_start_accept, .tx_done_ok, .tx_stop, .tx_end_page_in,
		.tx_queue_full_flag, .collision, .backoff_req, .attempt_num,
		.rand_slots, .backoff_slots, .backoff_valid, .phy_full_duplex,
		.rx_frame_end, .rx_frame_len, .rx_tag_type, .rx_vlan_id,
		.rx_frame_drop, .rx_oversize, .device_awake, .wake_request,
		.flow_control_enable, .back_pressure_active, .mac_full_duplex,
		.media_select, .back_to_back_tx_enable, .tag_filter_enable, .vlan_id,
		.tag_precedence, .canonical_format_flag, .frame_limit,
		.high_water_page_threshold, .big_endian);
	mfv_host_model mfv_host_model_i (.clock, .host_cs_n, .host_rd_n,
		.host_wr_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe);

	always #5 clock = ~clock;

	task wrap_up;
		$display("err_count %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task rchk(input [4:0] a, input [8:0] e);
		mfv_host_model_i.rd(a, d, o);
		chk({o, d}, e);
	endtask
	task wr(input [4:0] a, input [7:0] v);
		mfv_host_model_i.wr(a, v);
	endtask
	task frm(input [10:0] l, input [15:0] t, input [11:0] v, input [1:0] e);
		@(posedge clock);
		rx_frame_len <= l;
		rx_tag_type <= t;
		rx_vlan_id <= v;
		rx_frame_end <= 1'b1;
		@(posedge clock);
		rx_frame_end <= 1'b0;
		#1 chk({rx_frame_drop, rx_oversize}, e);
	endtask
	task cmd(input e);
		@(posedge clock) transmit_start_cmd <= 1'b1;
		@(posedge clock) transmit_start_cmd <= 1'b0;
		#1 chk(tx_start_accept, e);
	endtask
	task bo(input [7:0] m, input [3:0] a, input [9:0] e);
		wr(5'h1b, m);
		@(posedge clock);
		attempt_num <= a;
		rand_slots <= 10'h3ff;
		backoff_req <= 1'b1;
		@(posedge clock) backoff_req <= 1'b0;
		#1 chk({backoff_valid, backoff_slots}, {1'b1, e});
	endtask
	task coll(input int n);
		repeat (n) begin
			@(posedge clock) collision <= 1'b1;
			@(posedge clock) collision <= 1'b0;
		end
		repeat (3) @(posedge clock);
	endtask
	task transmit_config_reg(input v);
		@(posedge clock) tcr_full_duplex <= v;
		repeat (3) @(posedge clock);
	endtask

	task t_reset;
		rchk(5'h19, 9'h106);
		rchk(5'h1a, 9'h107);
		rchk(5'h1c, 9'h100);
		chk(frame_limit, 11'h600);
		chk({flow_control_enable, big_endian, media_select}, 3'h0);
	endtask
	task t_regs;
		wr(5'h19, 8'hff);
		wr(5'h18, 8'h10);
		wr(5'h1a, 8'hc5);
		wr(5'h1e, 8'h80);
		rchk(5'h19, 9'h107);
		chk(frame_limit, 11'h710);
		chk({flow_control_enable, high_water_page_threshold}, 7'h45);
		chk(big_endian, 1'b1);
		wr(5'h1e, 8'h00);
		chk(big_endian, 1'b0);
		mfv_host_model_i.rd(5'h1d, d, o);
		chk(o, 1'b0);
	endtask
	task t_duplex;
		@(posedge clock) phy_full_duplex <= 1'b1;
		wr(5'h1b, 8'h10);
		chk({media_select, mac_full_duplex}, 2'h2);
		rchk(5'h1b, 9'h110);
		transmit_config_reg(1'b1);
		rchk(5'h1b, 9'h190);
		transmit_config_reg(1'b0);
		wr(5'h1b, 8'h90);
		chk(mac_full_duplex, 1'b1);
		wr(5'h1b, 8'h80);
		chk({media_select, mac_full_duplex}, 2'h1);
		@(posedge clock) phy_full_duplex <= 1'b0;
		repeat (3) @(posedge clock);
		rchk(5'h1b, 9'h100);
	endtask
	task t_bp;
		wr(5'h1b, 8'h10);
		chk(back_pressure_active, 1'b1);
		coll(24);
		chk(back_pressure_active, 1'b1);
		coll(1);
		chk(back_pressure_active, 1'b0);
		wr(5'h17, 8'h3f);
		chk(back_pressure_active, 1'b1);
		wr(5'h17, 8'h19);
		wr(5'h1b, 8'h50);
		chk(back_pressure_active, 1'b1);
		transmit_config_reg(1'b1);
		chk(back_pressure_active, 1'b0);
		transmit_config_reg(1'b0);
		wr(5'h1a, 8'h40);
		chk(back_pressure_active, 1'b0);
	endtask
	task t_vlan;
		wr(5'h1c, 8'h34);
		wr(5'h1d, 8'hb5);
		chk({tag_precedence, canonical_format_flag, vlan_id}, 16'hb534);
		wr(5'h1b, 8'h18);
		chk(tag_filter_enable, 1'b1);
		frm(11'h710, 16'h8100, 12'h534, 2'h0);
		frm(11'h040, 16'h8100, 12'h000, 2'h0);
		frm(11'h040, 16'h8100, 12'h123, 2'h2);
		frm(11'h040, 16'h0800, 12'h534, 2'h2);
		frm(11'h711, 16'h8100, 12'h534, 2'h3);
		wr(5'h1b, 8'h10);
		frm(11'h040, 16'h0800, 12'h123, 2'h0);
	endtask
	task t_tx;
		@(posedge clock);
		tx_end_page_in <= 7'h45;
		tx_done_ok <= 1'b1;
		tx_queue_full_flag <= 1'b1;
		@(posedge clock) tx_done_ok <= 1'b0;
		rchk(5'h1c, 9'h1c5);
		@(posedge clock) tx_stop <= 1'b1;
		@(posedge clock) tx_stop <= 1'b0;
		rchk(5'h1c, 9'h180);
		@(posedge clock) tx_busy <= 1'b1;
		cmd(1'b0);
		wr(5'h1b, 8'h30);
		chk(back_to_back_tx_enable, 1'b1);
		cmd(1'b1);
	endtask
	task t_boff;
		mfv_host_model_i.test_en = 1'b1;
		bo(8'h01, 4'h5, 10'h000);
		bo(8'h04, 4'h1, 10'h002);
		bo(8'h04, 4'h2, 10'h000);
		bo(8'h04, 4'h3, 10'h007);
		bo(8'h02, 4'h5, 10'h003);
		bo(8'h00, 4'h4, 10'h00f);
		mfv_host_model_i.test_en = 1'b0;
	endtask
	task t_wake;
		wr(5'h1f, 8'h01);
		chk(wake_request, 1'b1);
		@(posedge clock) device_awake <= 1'b1;
		repeat (3) @(posedge clock);
		chk(wake_request, 1'b0);
	endtask

	initial begin
		#200_000;
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		repeat (6) @(posedge clock);
		t_reset;
		t_regs;
		t_duplex;
		t_bp;
		t_vlan;
		t_tx;
		t_boff;
		t_wake;
		wrap_up;
	end
endmodule
